// *** pkg/srgc_map.svh ***
// Purpose: offsets-free timing counts and widths for the rectifier gate control
// Assumes: 100 MHz device clock, 10 ns period
// Notes: times in ns with derived cycle counts; least times round up
`ifndef SRGC_MAP_SVH
`define SRGC_MAP_SVH

`define SRGC_CLK_PERIOD_NS 10
// default internal minimum conduction time, ns
`define SRGC_MIN_CONDUCT_NS 1000
`define SRGC_MIN_CONDUCT_CYC ((`SRGC_MIN_CONDUCT_NS + `SRGC_CLK_PERIOD_NS - 1) / `SRGC_CLK_PERIOD_NS)
// default internal minimum off time, ns
`define SRGC_MIN_OFF_NS 1000
`define SRGC_MIN_OFF_CYC ((`SRGC_MIN_OFF_NS + `SRGC_CLK_PERIOD_NS - 1) / `SRGC_CLK_PERIOD_NS)
// trigger blanking after turn-on, ns
`define SRGC_TRIG_BLANK_NS 100
`define SRGC_TRIG_BLANK_CYC ((`SRGC_TRIG_BLANK_NS + `SRGC_CLK_PERIOD_NS - 1) / `SRGC_CLK_PERIOD_NS)
// trigger high time before disable, ns
`define SRGC_DIS_ENTRY_NS 100000
`define SRGC_DIS_ENTRY_CYC ((`SRGC_DIS_ENTRY_NS + `SRGC_CLK_PERIOD_NS - 1) / `SRGC_CLK_PERIOD_NS)
// trigger low time to leave disable, ns
`define SRGC_DIS_EXIT_NS 1000
`define SRGC_DIS_EXIT_CYC ((`SRGC_DIS_EXIT_NS + `SRGC_CLK_PERIOD_NS - 1) / `SRGC_CLK_PERIOD_NS)
// recovery after disable, ns
`define SRGC_RECOVER_NS 3000
`define SRGC_RECOVER_CYC ((`SRGC_RECOVER_NS + `SRGC_CLK_PERIOD_NS - 1) / `SRGC_CLK_PERIOD_NS)
// timer width
`define SRGC_CNT_W 20
`define SRGC_CHAN_W 4

`endif

// *** pkg/srgc_pkg.sv ***
// Purpose: shared types for the rectifier gate control
// Assumes: nothing beyond the map header
// Notes: mode encodings left to the tool
package srgc_pkg;
  typedef enum {SRGC_NORMAL, SRGC_DISABLED, SRGC_RECOVER} srgc_mode_type;
  typedef enum {SRGC_ARMWAIT, SRGC_IDLE, SRGC_ON} srgc_drive_type;
endpackage : srgc_pkg

// *** pkg/srgc_sync_if.sv ***
// Purpose: carries synchronised comparator and trigger levels inside the block
// Assumes: one clock domain
// Notes: the producer drives, the consumer reads
`timescale 1ns/1ps
`default_nettype none
interface srgc_sync_if;
  logic cs_below_on;
  logic cs_above_off;
  logic cs_above_reset;
  logic trigger_high;
  modport producer (output cs_below_on, output cs_above_off, output cs_above_reset,
    output trigger_high);
  modport consumer (input cs_below_on, input cs_above_off, input cs_above_reset,
    input trigger_high);
endinterface : srgc_sync_if
`default_nettype wire

// *** design/srgc_sync.sv ***
// Purpose: two-flop synchronisers for the comparator and trigger pins
// Assumes: inputs are asynchronous to i_clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
`include "srgc_map.svh"
module srgc_sync #(
  parameter int N = `SRGC_CHAN_W
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [N-1:0] i_async,
  srgc_sync_if.producer o_sync
);
  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;

  initial begin
    if (N != 4) $error("srgc_sync serves exactly four channels");
  end

  // one synchroniser per channel
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign o_sync.cs_below_on = sync_q[0];
  assign o_sync.cs_above_off = sync_q[1];
  assign o_sync.cs_above_reset = sync_q[2];
  assign o_sync.trigger_high = sync_q[3];
endmodule : srgc_sync
`default_nettype wire

// *** design/srgc_timer.sv ***
// Purpose: loadable down-counting interval timer
// Assumes: load wins over run
// Notes: done is a level while the count stands at one and not busy
`timescale 1ns/1ps
`default_nettype none
module srgc_timer #(
  parameter int W = 20
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_clear,
  input wire logic [W-1:0] i_cycles,
  output logic o_busy,
  output logic o_done
);
  logic [W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  initial begin
    if (W < 2) $error("srgc_timer width too small");
  end

  // count down to one, then flag done until cleared or restarted
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_clear) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_start) begin
      cnt_q <= i_cycles;
      busy_q <= (i_cycles > W'(1));
      done_q <= (i_cycles <= W'(1));
    end else if (busy_q) begin
      cnt_q <= cnt_q - W'(1);
      busy_q <= (cnt_q > W'(2));
      done_q <= (cnt_q <= W'(2));
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule : srgc_timer
`default_nettype wire

// *** design/srgc_gate_ctrl.sv ***
// Purpose: gate drive control of a secondary synchronous rectifier switch
// Assumes: comparator outputs and trigger arrive as digital levels, asynchronous
// Notes: intervals are cycle counts; external settings select over internal ones
`timescale 1ns/1ps
`default_nettype none
`include "srgc_map.svh"
module srgc_gate_ctrl
  import srgc_pkg::*;
#(
  parameter int CNT_W = `SRGC_CNT_W,
  parameter int DIS_ENTRY_CYC = `SRGC_DIS_ENTRY_CYC,
  parameter int MIN_CONDUCT_CYC = `SRGC_MIN_CONDUCT_CYC,
  parameter int MIN_OFF_CYC = `SRGC_MIN_OFF_CYC
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_turn_on_threshold,
  input wire logic i_turn_off_threshold,
  input wire logic i_offtime_reset_threshold,
  input wire logic i_trigger_disable_in,
  input wire logic i_min_conduction_ext,
  input wire logic [CNT_W-1:0] i_min_conduction_setting,
  input wire logic i_min_offtime_ext,
  input wire logic [CNT_W-1:0] i_min_offtime_setting,
  output logic o_gate_drive_out,
  output logic o_disable_mode,
  output logic o_low_power
);
  import srgc_pkg::*;

  // fixed intervals; only the minimum conduction and off times have pin settings, the rest
  // are built in and must fit the counter width; of these only DIS_ENTRY is checked below
  localparam logic [CNT_W-1:0] TRIG_BLANK = CNT_W'(`SRGC_TRIG_BLANK_CYC);
  localparam logic [CNT_W-1:0] DIS_EXIT = CNT_W'(`SRGC_DIS_EXIT_CYC);
  localparam logic [CNT_W-1:0] RECOVER = CNT_W'(`SRGC_RECOVER_CYC);
  localparam logic [CNT_W-1:0] DIS_ENTRY = CNT_W'(DIS_ENTRY_CYC);

  initial begin
    if (CNT_W < 8 || CNT_W > 31) $error("srgc_gate_ctrl counter width out of range");
    if (DIS_ENTRY_CYC >= (1 << CNT_W) || MIN_CONDUCT_CYC >= (1 << CNT_W) ||
        MIN_OFF_CYC >= (1 << CNT_W)) $error("srgc_gate_ctrl count exceeds counter");
    if (MIN_CONDUCT_CYC < 1 || MIN_OFF_CYC < 1) $error("srgc_gate_ctrl zero interval");
  end

  // pin order fixes the channel map of the synchroniser below
  logic [3:0] pins;
  assign pins = {i_trigger_disable_in, i_offtime_reset_threshold, i_turn_off_threshold,
    i_turn_on_threshold};

  // synchronised inputs; the comparator and trigger pins are asynchronous to the device clock
  srgc_sync_if sif ();
  srgc_sync #(
    .N(4)
  ) u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_async(pins),
    .o_sync(sif.producer)
  );

  logic below_on;
  logic above_off;
  logic above_rst;
  logic trig;
  assign below_on = sif.cs_below_on;
  assign above_off = sif.cs_above_off;
  assign above_rst = sif.cs_above_reset;
  assign trig = sif.trigger_high;

  srgc_drive_type drv_q;
  srgc_mode_type mode_q;
  logic below_on_q;
  logic above_rst_q;
  logic gate_q;
  logic [CNT_W-1:0] blank_q;
  logic [CNT_W-1:0] trig_hi_q;
  logic [CNT_W-1:0] trig_lo_q;
  logic [CNT_W-1:0] rec_q;

  // interval selection: pin setting or built-in value
  logic [CNT_W-1:0] con_cycles;
  logic [CNT_W-1:0] off_cycles;
  assign con_cycles = i_min_conduction_ext ? i_min_conduction_setting
                                           : CNT_W'(MIN_CONDUCT_CYC);
  assign off_cycles = i_min_offtime_ext ? i_min_offtime_setting
                                        : CNT_W'(MIN_OFF_CYC);

  // turn-on crossing history; resets high, but the synchroniser resets low, so a level present at start-up still shows as a crossing
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      below_on_q <= 1'b1;
    end else begin
      below_on_q <= below_on;
    end
  end

  // reset-comparator history; a pin already high after reset counts as a rise,
  // so the first off time starts without waiting for a stroke
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      above_rst_q <= 1'b0;
    end else begin
      above_rst_q <= above_rst;
    end
  end

  logic fall_cross;
  logic rise_rst;
  assign fall_cross = below_on && !below_on_q;
  assign rise_rst = above_rst && !above_rst_q;

  // for turn-off, trigger is seen only outside the blanking window
  logic blanking;
  logic trig_eff;
  assign blanking = (drv_q == SRGC_ON) && (blank_q != '0);
  assign trig_eff = trig && !blanking;

  // minimum conduction timer
  logic con_start;
  logic con_busy;
  logic turn_on;
  logic turn_off;
  logic normal;
  assign normal = (mode_q == SRGC_NORMAL);
  // a crossing, not a level, starts a pulse; the raw trigger blocks it because
  // blanking only exists once a pulse is running
  assign turn_on = (drv_q == SRGC_IDLE) && normal && fall_cross && !trig;
  assign con_start = turn_on;
  srgc_timer #(
    .W(CNT_W)
  ) u_con (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_start(con_start),
    .i_clear(1'b0),
    .i_cycles(con_cycles),
    .o_busy(con_busy),
    .o_done()
  );
  // trigger wins over min conduction; sense waits for it
  assign turn_off = (drv_q == SRGC_ON) &&
                    (trig_eff || !normal || (above_off && !con_busy));

  // off-time timer: start on rise, clear on ringing back below
  logic off_start;
  logic off_clear;
  logic off_done;
  assign off_start = rise_rst && (drv_q == SRGC_ARMWAIT) && (mode_q != SRGC_DISABLED);
  // a done level left from before disable must not arm the drive after recovery
  assign off_clear = !above_rst ||
                     turn_on ||
                     (drv_q == SRGC_ON) ||
                     (mode_q == SRGC_DISABLED);
  srgc_timer #(
    .W(CNT_W)
  ) u_off (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_start(off_start),
    .i_clear(off_clear),
    .i_cycles(off_cycles),
    .o_busy(),
    .o_done(off_done)
  );

  // drive state: arm only after complete off time
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      drv_q <= SRGC_ARMWAIT;
    end else begin
      unique case (drv_q)
        SRGC_ARMWAIT: begin
          if (off_done && normal) begin
            drv_q <= SRGC_IDLE;
          end
        end
        SRGC_IDLE: begin
          if (!normal) begin
            drv_q <= SRGC_ARMWAIT;
          end else if (turn_on) begin
            drv_q <= SRGC_ON;
          end
        end
        SRGC_ON: begin
          if (turn_off) begin
            drv_q <= SRGC_ARMWAIT;
          end
        end
      endcase
    end
  end

  // gate output register, cleared in the same edge as the off decision
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_q <= 1'b0;
    end else if (turn_on) begin
      gate_q <= 1'b1;
    end else if (turn_off || drv_q != SRGC_ON) begin
      gate_q <= 1'b0;
    end
  end

  // trigger blanking counter loaded at turn-on
  // turn-on reloads even if a count remains from a pulse cut short
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      blank_q <= '0;
    end else if (turn_on) begin
      blank_q <= TRIG_BLANK;
    end else if (blank_q != '0) begin
      blank_q <= blank_q - CNT_W'(1);
    end
  end

  // time the trigger has been high, saturating at the disable entry count
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_hi_q <= '0;
    end else if (!trig) begin
      trig_hi_q <= '0;
    end else if (trig_hi_q != DIS_ENTRY) begin
      trig_hi_q <= trig_hi_q + CNT_W'(1);
    end
  end

  // time the trigger has been low, saturating at the exit count; a glitch restarts it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_lo_q <= '0;
    end else if (trig) begin
      trig_lo_q <= '0;
    end else if (trig_lo_q != DIS_EXIT) begin
      trig_lo_q <= trig_lo_q + CNT_W'(1);
    end
  end

  // disable mode and recovery; once recovery runs, trigger may rise again
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q <= SRGC_NORMAL;
      rec_q <= '0;
    end else begin
      unique case (mode_q)
        SRGC_NORMAL: begin
          if (trig_hi_q == DIS_ENTRY) begin
            mode_q <= SRGC_DISABLED;
          end
        end
        SRGC_DISABLED: begin
          if (trig_lo_q == DIS_EXIT) begin
            mode_q <= SRGC_RECOVER;
            rec_q <= RECOVER;
          end
        end
        SRGC_RECOVER: begin
          if (rec_q <= CNT_W'(1)) begin
            mode_q <= SRGC_NORMAL;
            rec_q <= '0;
          end else begin
            rec_q <= rec_q - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // status outputs registered so the pins come straight from flops
  logic dis_q;
  logic lp_q;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      dis_q <= 1'b0;
    end else begin
      dis_q <= (mode_q == SRGC_DISABLED);
    end
  end

  // low-power request; kept apart so a later variant may drop it earlier than disable
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      lp_q <= 1'b0;
    end else begin
      lp_q <= (mode_q == SRGC_DISABLED); // reduced consumption while disabled
    end
  end

  assign o_gate_drive_out = gate_q;
  assign o_disable_mode = dis_q;
  assign o_low_power = lp_q;
endmodule : srgc_gate_ctrl
`default_nettype wire

// *** tb/srgc_gate_ctrl_properties.sv ***
// Purpose: port checks on the rectifier gate control
// Assumes: one clock, async active-low reset
// Notes: pin-to-drive latency allowed as two samples
`timescale 1ns/1ps
`default_nettype none
module srgc_gate_ctrl_properties #(
  parameter int DIS_ENTRY_CYC = 300
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_turn_on_threshold,
  input wire logic i_turn_off_threshold,
  input wire logic i_trigger_disable_in,
  input wire logic o_gate_drive_out,
  input wire logic o_disable_mode,
  input wire logic o_low_power
);
  logic [19:0] trig_cnt_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // length of the present trigger-high run, saturating so it never wraps
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_cnt_q <= '0;
    end else if (!i_trigger_disable_in) begin
      trig_cnt_q <= '0;
    end else if (trig_cnt_q != 20'hfffff) begin
      trig_cnt_q <= trig_cnt_q + 20'h1;
    end
  end
  a_trig_forces_off: assert property (trig_cnt_q >= 20'd20 |-> !o_gate_drive_out)
    else $error("drive high under long trigger");
  a_trig_blocks_on: assert property (trig_cnt_q >= 20'd4 |-> !$rose(o_gate_drive_out))
    else $error("drive rose under trigger");
  a_on_needs_sense: assert property ($rose(o_gate_drive_out) |->
    $past(i_turn_on_threshold, 2) && !$past(i_trigger_disable_in, 2))
    else $error("drive rose without turn-on cause");
  a_blank_holds_on: assert property ($rose(o_gate_drive_out) |-> o_gate_drive_out[*8])
    else $error("drive pulse cut inside blanking");
  a_off_has_cause: assert property ($fell(o_gate_drive_out) |->
    $past(i_turn_off_threshold, 2) || $past(i_trigger_disable_in, 2))
    else $error("drive fell without cause");
  a_disable_entry: assert property (trig_cnt_q >= 20'(DIS_ENTRY_CYC + 6) |-> o_disable_mode)
    else $error("disable mode not entered");
  a_disable_early: assert property ($rose(o_disable_mode) |->
    trig_cnt_q >= 20'(DIS_ENTRY_CYC))
    else $error("disable mode entered early");
  a_disable_quiet: assert property (o_disable_mode |-> !o_gate_drive_out && o_low_power)
    else $error("disable mode not quiet");
  c_drive_on: cover property ($rose(o_gate_drive_out));
  c_trig_off: cover property ($fell(o_gate_drive_out) && $past(i_trigger_disable_in, 2));
  c_disable: cover property ($rose(o_disable_mode));
endmodule : srgc_gate_ctrl_properties
`default_nettype wire

// *** tb/srgc_far_side.sv ***
// Purpose: model of the power switch sense levels and primary trigger
// Assumes: drives change one step after a rising clock edge
// Notes: comparator levels are digital, as the block expects
`timescale 1ns/1ps
`default_nettype none
module srgc_far_side (
  input wire logic i_clock,
  output var logic o_below_on,
  output var logic o_above_off,
  output var logic o_above_reset,
  output var logic o_trigger
);
  // idle: switch voltage high, trigger low
  initial begin
    o_below_on = 1'b0;
    o_above_off = 1'b1;
    o_above_reset = 1'b1;
    o_trigger = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  // one secondary stroke: diode drop, conduction, zero current, voltage back up
  task automatic stroke(input int conduct, input int tail);
    tick(1);
    o_above_reset = 1'b0;
    o_above_off = 1'b0;
    o_below_on = 1'b1;
    tick(conduct);
    o_below_on = 1'b0;
    o_above_off = 1'b1;
    tick(tail);
    o_above_reset = 1'b1;
  endtask : stroke
  // ringing dip below the reset level
  task automatic ring(input int n);
    tick(1);
    o_above_reset = 1'b0;
    tick(n);
    o_above_reset = 1'b1;
  endtask : ring
  // raised early in the stroke to keep the cross-conduction overlap short
  task automatic set_trigger(input logic v);
    tick(1);
    o_trigger = v;
  endtask : set_trigger
  // trigger held low long enough to end disable mode
  task automatic exit_disable(input int hold);
    set_trigger(1'b0);
    tick(hold);
  endtask : exit_disable
endmodule : srgc_far_side
`default_nettype wire

// *** tb/tb_srgc_gate_ctrl.sv ***
// Purpose: self-checking bench for the rectifier gate control
// Assumes: shortened disable entry count, internal times of 20 cycles
// Notes: pulse lengths are counted in clock cycles of drive high
`timescale 1ns/1ps
`default_nettype none
module tb_srgc_gate_ctrl;
  localparam int CON = 20;
  localparam int OFF = 20;
  localparam int DIS = 300;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic ext_con = 1'b0;
  logic ext_off = 1'b0;
  logic [19:0] set_con = 20'h0;
  logic [19:0] set_off = 20'h0;
  logic below_on, above_off, above_reset, trig;
  logic o_gate_drive_out, o_disable_mode, o_low_power;
  int on_len = 0;
  int last_len = 0;
  int pulses = 0;
  int failures = 0;
  int compares = 0;
  always #5 i_clock = ~i_clock;
  srgc_far_side u_far (.i_clock(i_clock), .o_below_on(below_on), .o_above_off(above_off),
    .o_above_reset(above_reset), .o_trigger(trig));
  srgc_gate_ctrl #(.DIS_ENTRY_CYC(DIS), .MIN_CONDUCT_CYC(CON), .MIN_OFF_CYC(OFF)) u_dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_turn_on_threshold(below_on),
    .i_turn_off_threshold(above_off), .i_offtime_reset_threshold(above_reset),
    .i_trigger_disable_in(trig), .i_min_conduction_ext(ext_con),
    .i_min_conduction_setting(set_con), .i_min_offtime_ext(ext_off),
    .i_min_offtime_setting(set_off), .o_gate_drive_out(o_gate_drive_out),
    .o_disable_mode(o_disable_mode), .o_low_power(o_low_power));
  // count and measure drive pulses as they end
  always @(posedge i_clock) begin
    if (o_gate_drive_out === 1'b1) begin
      on_len++;
    end else if (on_len != 0) begin
      last_len = on_len;
      pulses++;
      on_len = 0;
    end
  end
  task automatic check_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit
  task automatic check_range(input string name, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      failures++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_range
  task automatic s_min_conduction();
    int n;
    n = pulses;
    set_con = 20'hfffff; // settings hold absurd values while the built-in ones are chosen
    set_off = 20'hfffff;
    u_far.stroke(2, 40);
    u_far.tick(30);
    check_range("pulse count", n + 1, n + 1, pulses);
    check_range("internal min on", CON, CON + 4, last_len);
    ext_con = 1'b1;
    set_con = 20'h28;
    u_far.stroke(2, 60);
    u_far.tick(30);
    check_range("external min on", 40, 44, last_len);
    u_far.stroke(60, 5);
    u_far.tick(30);
    check_range("sense turn-off", 57, 63, last_len);
    ext_con = 1'b0;
  endtask : s_min_conduction
  task automatic s_offtime();
    int n;
    ext_off = 1'b1;
    set_off = 20'h28;
    n = pulses;
    u_far.stroke(30, 5);
    u_far.tick(10);
    u_far.stroke(30, 5);
    check_range("turn-on in off time", n + 1, n + 1, pulses);
    u_far.tick(25);
    u_far.ring(5);
    u_far.tick(25);
    u_far.stroke(30, 5);
    check_range("ringing restarts off time", n + 1, n + 1, pulses);
    u_far.tick(50);
    u_far.stroke(30, 5);
    u_far.tick(5);
    check_range("turn-on after off time", n + 2, n + 2, pulses);
    ext_off = 1'b0;
  endtask : s_offtime
  task automatic s_trigger();
    int n;
    n = pulses;
    u_far.tick(60); // the 40-cycle off time started by the last stroke must run out first
    fork
      u_far.stroke(60, 5);
      begin
        while (o_gate_drive_out !== 1'b1 && n < 100000) begin
          u_far.tick(1);
          n++;
        end
        n = pulses;
        u_far.set_trigger(1'b1);
        u_far.tick(5);
        check_bit("drive in trigger blank", 1'b1, o_gate_drive_out);
        u_far.tick(10);
        check_bit("trigger turn-off", 1'b0, o_gate_drive_out);
      end
    join
    u_far.tick(40);
    fork
      u_far.stroke(40, 5);
      begin
        u_far.tick(10);
        u_far.set_trigger(1'b0);
      end
    join
    check_range("no drive under trigger or level", n + 1, n + 1, pulses);
  endtask : s_trigger
  task automatic s_disable();
    int n;
    n = pulses;
    u_far.set_trigger(1'b1);
    u_far.tick(DIS + 10);
    check_bit("disable mode", 1'b1, o_disable_mode);
    check_bit("low power", 1'b1, o_low_power);
    u_far.stroke(30, 5);
    u_far.exit_disable(120);
    u_far.tick(50);
    u_far.stroke(30, 5);
    check_range("no drive in disable or recovery", n, n, pulses);
    u_far.tick(300);
    check_bit("disable left", 1'b0, o_disable_mode);
    u_far.stroke(30, 5);
    u_far.tick(OFF + 10);
    u_far.stroke(30, 5);
    u_far.tick(5);
    check_range("drive back after recovery", n + 2, n + 2, pulses);
  endtask : s_disable
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // main sequence: reset, arm with a full off time, then the scenarios
  initial begin
    repeat (10) @(posedge i_clock);
    #1;
    i_resetn = 1'b1;
    u_far.ring(3);
    u_far.tick(OFF + 10);
    s_min_conduction();
    s_offtime();
    s_trigger();
    s_disable();
    print_verdict();
  end
  // watchdog well beyond the roughly 1750 cycles the run needs
  initial begin
    #200us;
    failures++;
    print_verdict();
  end
endmodule : tb_srgc_gate_ctrl
bind srgc_gate_ctrl srgc_gate_ctrl_properties #(.DIS_ENTRY_CYC(DIS_ENTRY_CYC)) u_props (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_turn_on_threshold(i_turn_on_threshold),
  .i_turn_off_threshold(i_turn_off_threshold), .i_trigger_disable_in(i_trigger_disable_in),
  .o_gate_drive_out(o_gate_drive_out), .o_disable_mode(o_disable_mode),
  .o_low_power(o_low_power));
`default_nettype wire
